/* verilog/bmp_pkg.sv */
/*
 * Shared constants and types for the motion-profile block of a brushless
 * DC positioning controller: register byte offsets, control bit positions,
 * reset values, timing counts, the sequencer states and the settings, measurement and drive records.
 * Assumes a 25 MHz system clock and an Avalon-MM register port with 32-bit data.
 */
// What this block does
// - Direction invert flips position counting sign.
// - Run-at-maximum replaces working speed with maximum.
// - Speed limiting clamps speed to maximum nominal.
// - Over speed (with speed limiting on) or current reduces drive, keeps moving.
// - Current setting means peak or thermal value.
// - Ultra-low mode divides working speed by 1000.
// - Backlash mode overshoots, then returns from one side.
// - Sign of backlash count picks approach side.
// - Backlash return uses its own speed.
// - Acceleration mode ramps up and down.
// - Encoder input single-ended, differential or automatic.
// - Encoder counts per turn scale feedback.
// - Pole count drives electrical angle.
// - First move after power-up aligns rotor.
// - Terminal-to-terminal voltage held under maximum.
package bmp_pkg;

    // Register byte offsets on the Avalon-MM port.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORK_SPEED = 8'h04;
    localparam logic [7:0] OFS_MAX_SPEED = 8'h08;
    localparam logic [7:0] OFS_BL_STEPS = 8'h0c;
    localparam logic [7:0] OFS_BL_SPEED = 8'h10;
    localparam logic [7:0] OFS_ACCEL = 8'h14;
    localparam logic [7:0] OFS_DECEL = 8'h18;
    localparam logic [7:0] OFS_POLES = 8'h1c;
    localparam logic [7:0] OFS_ENC_CPT = 8'h20;
    localparam logic [7:0] OFS_MAX_VOLT = 8'h24;
    localparam logic [7:0] OFS_NOM_CURR = 8'h28;
    localparam logic [7:0] OFS_TARGET = 8'h2c;
    localparam logic [7:0] OFS_CMD = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_POSITION = 8'h38;
    localparam logic [7:0] OFS_ENC_POS = 8'h3c;
    localparam logic [7:0] OFS_CUR_SPEED = 8'h40;

    // Control register bit positions.
    localparam int CB_INVERT = 0;
    localparam int CB_RUN_MAX = 1;
    localparam int CB_LIMIT = 2;
    localparam int CB_AMP = 3;
    localparam int CB_ULTRA = 4;
    localparam int CB_BL_EN = 5;
    localparam int CB_ACC_EN = 6;
    localparam int CB_ENC_LO = 7;
    // Command register bit positions.
    localparam int CMD_GO = 0;
    localparam int CMD_STOP = 1;

    // Encoder input selection codes.
    localparam logic [1:0] ENC_SINGLE = 2'h0;
    localparam logic [1:0] ENC_DIFF = 2'h1;
    localparam logic [1:0] ENC_AUTO = 2'h2;

    // Reset values of the settings.
    localparam logic [23:0] RST_WORK_SPEED = 24'h0003e8;
    localparam logic [23:0] RST_MAX_SPEED = 24'h002710;
    localparam logic [23:0] RST_BL_SPEED = 24'h0000c8;
    localparam logic [23:0] RST_ACCEL = 24'h0003e8;
    localparam logic [23:0] RST_DECEL = 24'h0003e8;
    localparam logic [7:0] RST_POLES = 8'h08;
    localparam logic [15:0] RST_ENC_CPT = 16'h0fa0;
    localparam logic [15:0] RST_MAX_VOLT = 16'h2ee0;
    localparam logic [15:0] RST_NOM_CURR = 16'h01f4;

    // Timing: clock rate, profile update period and derived counts.
    localparam longint CLK_HZ = 25_000_000;
    localparam longint PROFILE_PERIOD_US = 1000;
    localparam logic [14:0] PROFILE_CYCLES = 15'(CLK_HZ * PROFILE_PERIOD_US / 1_000_000 - 1);
    // Speeds run internally in millisteps per second.
    localparam logic [31:0] MILLI = 32'd1000;
    localparam logic [35:0] STEP_THRESH = 36'(CLK_HZ * 1000);
    localparam logic [31:0] MIN_MPS = 32'd1000;
    // Braking test factor: 2 times millisteps squared per step squared.
    localparam logic [79:0] BRAKE_K = 80'd2_000_000;
    // Thermal current to peak amplitude, sqrt(2) as 181/128.
    localparam logic [23:0] PEAK_NUM = 24'd181;
    localparam int PEAK_SHIFT = 7;
    localparam logic [7:0] ANGLE_PER_PAIR = 8'hff;

    // Motion sequencer states, one-hot.
    typedef enum logic [3:0] {
        BMP_IDLE = 4'b0001,
        BMP_MAIN = 4'b0010,
        BMP_RETURN = 4'b0100,
        BMP_HOLD = 4'b1000
    } bmp_mode_e;

    // Software-visible motion settings.
    typedef struct packed {
        logic invert;
        logic run_max;
        logic limit;
        logic amp;
        logic ultra;
        logic bl_en;
        logic acc_en;
        logic [1:0] enc_type;
        logic [23:0] work_speed;
        logic [23:0] max_speed;
        logic signed [15:0] bl_steps;
        logic [23:0] bl_speed;
        logic [23:0] accel;
        logic [23:0] decel;
        logic [7:0] poles;
        logic [15:0] enc_cpt;
        logic [15:0] max_volt;
        logic [15:0] nom_curr;
        logic signed [31:0] target;
    } bmp_cfg_s;

    // Measured motor quantities from the drive stage.
    typedef struct packed {
        logic [23:0] speed;
        logic [15:0] current;
        logic [15:0] voltage;
    } bmp_meas_s;

    // Commands towards the drive stage.
    typedef struct packed {
        logic step;
        logic dir;
        logic [7:0] duty;
        logic [7:0] angle;
        logic [15:0] current_ref;
        logic current_is_peak;
    } bmp_drive_s;

endpackage

/* verilog/bmp_motion_ctrl.sv */
/*
 * Motion profile, backlash sequencing, limiting and encoder feedback of a
 * brushless DC positioning controller, with an Avalon-MM register slave.
 * Assumes all inputs are synchronous to the 25 MHz clock and that the drive
 * stage turns the duty, direction and angle outputs into winding voltages.
 */
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module bmp_motion_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enc_a_p,
    input wire logic enc_a_n,
    input wire logic enc_b_p,
    input wire logic enc_b_n,
    input wire bmp_pkg::bmp_meas_s meas,
    output bmp_pkg::bmp_drive_s drive,
    output logic busy,
    output logic rotor_aligned
);

    // Whole state of the block in one record.
    typedef struct packed {
        bmp_pkg::bmp_cfg_s cfg;
        bmp_pkg::bmp_cfg_s run;
        bmp_pkg::bmp_mode_e mode;
        logic overshoot;
        logic signed [31:0] pos;
        logic signed [31:0] enc_pos;
        logic signed [31:0] goal;
        logic [31:0] cur_mps;
        logic [35:0] step_acc;
        logic [14:0] ms_cnt;
        logic dir;
        logic step;
        logic [7:0] duty;
        logic [7:0] angle;
        logic [23:0] ang_frac;
        logic qa;
        logic qb;
        logic diff_bad;
        logic aligned;
        logic limited;
        logic ack;
        logic [31:0] rdata;
    } bmp_state_s;

    bmp_state_s st;
    bmp_state_s next_st;

    // Combinational helpers derived from the present state and the inputs.
    logic [31:0] wmask;
    logic [31:0] leg_speed;
    logic [31:0] tgt_mps;
    logic [31:0] floor_mps;
    logic [31:0] remaining;
    logic [63:0] v_sq;
    logic [79:0] brake_dist;
    logic ms_tick;
    logic use_diff;
    logic enc_a;
    logic enc_b;
    logic signed [31:0] enc_delta;
    logic [23:0] peak_curr;
    logic over_limit;

    // Stall the master for exactly one cycle on every access.
    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata = st.rdata;
    assign busy = (st.mode != bmp_pkg::BMP_IDLE);
    assign rotor_aligned = st.aligned;

    // Drive outputs from state flip-flops; direction is XORed with invert, current reference derived from the latched setting.
    always_comb begin
        drive.step = st.step;
        drive.dir = st.dir ^ st.run.invert;
        drive.duty = st.duty;
        drive.angle = st.angle;
        drive.current_is_peak = st.run.amp;
        drive.current_ref = st.run.amp ? st.run.nom_curr : peak_curr[15:0];
    end

    // Thermal current scaled up to its peak amplitude for the current loop.
    assign peak_curr = (24'(st.run.nom_curr) * bmp_pkg::PEAK_NUM) >> bmp_pkg::PEAK_SHIFT;

    // Byte-enable mask for partial writes.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end

    // Speed of the present leg after run-at-maximum, limit and ultra-low scaling.
    always_comb begin
        leg_speed = 32'(st.run.work_speed);
        if (st.run.run_max) begin
            leg_speed = 32'(st.run.max_speed);
        end
        if (st.mode == bmp_pkg::BMP_RETURN) begin
            leg_speed = 32'(st.run.bl_speed);
        end
        if (st.run.limit && leg_speed > 32'(st.run.max_speed)) begin
            leg_speed = 32'(st.run.max_speed);
        end
        if (st.run.ultra && st.mode != bmp_pkg::BMP_RETURN) begin
            tgt_mps = leg_speed;
        end else begin
            tgt_mps = 32'(64'(leg_speed) * 64'(bmp_pkg::MILLI));
        end
        floor_mps = (tgt_mps < bmp_pkg::MIN_MPS) ? tgt_mps : bmp_pkg::MIN_MPS;
    end

    // Distance left and the braking test of the deceleration ramp.
    always_comb begin
        remaining = (st.goal > st.pos) ? 32'(st.goal - st.pos) : 32'(st.pos - st.goal);
        v_sq = 64'(st.cur_mps) * 64'(st.cur_mps);
        brake_dist = 80'(st.run.decel) * 80'(remaining) * bmp_pkg::BRAKE_K;
    end

    assign ms_tick = (st.ms_cnt == bmp_pkg::PROFILE_CYCLES);

    // Encoder input selection: automatic falls back once both pairs look single-ended.
    always_comb begin
        case (st.cfg.enc_type)
            bmp_pkg::ENC_DIFF: use_diff = 1'b1;
            bmp_pkg::ENC_AUTO: use_diff = ~st.diff_bad;
            default: use_diff = 1'b0;
        endcase
        enc_a = use_diff ? (enc_a_p & ~enc_a_n) : enc_a_p;
        enc_b = use_diff ? (enc_b_p & ~enc_b_n) : enc_b_p;
    end

    // Quadrature decode into a signed step of the position count.
    always_comb begin
        enc_delta = 32'sd0;
        if ((enc_a ^ st.qa) ^ (enc_b ^ st.qb)) begin
            enc_delta = ((enc_a ^ st.qb) ? 32'sd1 : -32'sd1);
        end
    end

    // Motor over its nominal speed (with speed limiting on), current or terminal voltage.
    always_comb begin
        over_limit = 1'b0;
        if (st.run.limit && meas.speed > st.run.max_speed) begin
            over_limit = 1'b1;
        end
        if (meas.current > st.run.nom_curr) begin
            over_limit = 1'b1;
        end
        if (meas.voltage > st.run.max_volt) begin
            over_limit = 1'b1;
        end
    end

    // Next-state logic of the whole block.
    always_comb begin
        next_st = st;
        next_st.step = 1'b0;
        next_st.ms_cnt = ms_tick ? 15'h0000 : st.ms_cnt + 15'h0001;
        next_st.limited = over_limit;

        // Register read is captured while waitrequest is high.
        if ((avs_read | avs_write) && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = 32'h00000000;
            case (avs_address)
                bmp_pkg::OFS_CTRL: next_st.rdata = {23'h000000, st.cfg.enc_type,
                    st.cfg.acc_en, st.cfg.bl_en, st.cfg.ultra, st.cfg.amp,
                    st.cfg.limit, st.cfg.run_max, st.cfg.invert};
                bmp_pkg::OFS_WORK_SPEED: next_st.rdata = 32'(st.cfg.work_speed);
                bmp_pkg::OFS_MAX_SPEED: next_st.rdata = 32'(st.cfg.max_speed);
                bmp_pkg::OFS_BL_STEPS: next_st.rdata = 32'(st.cfg.bl_steps);
                bmp_pkg::OFS_BL_SPEED: next_st.rdata = 32'(st.cfg.bl_speed);
                bmp_pkg::OFS_ACCEL: next_st.rdata = 32'(st.cfg.accel);
                bmp_pkg::OFS_DECEL: next_st.rdata = 32'(st.cfg.decel);
                bmp_pkg::OFS_POLES: next_st.rdata = 32'(st.cfg.poles);
                bmp_pkg::OFS_ENC_CPT: next_st.rdata = 32'(st.cfg.enc_cpt);
                bmp_pkg::OFS_MAX_VOLT: next_st.rdata = 32'(st.cfg.max_volt);
                bmp_pkg::OFS_NOM_CURR: next_st.rdata = 32'(st.cfg.nom_curr);
                bmp_pkg::OFS_TARGET: next_st.rdata = st.cfg.target;
                bmp_pkg::OFS_STATUS: next_st.rdata = {24'h000000, st.duty[7:4],
                    st.limited, use_diff, st.aligned, busy};
                bmp_pkg::OFS_POSITION: next_st.rdata = st.pos;
                bmp_pkg::OFS_ENC_POS: next_st.rdata = st.enc_pos;
                bmp_pkg::OFS_CUR_SPEED: next_st.rdata = st.cur_mps;
                default: next_st.rdata = 32'h00000000;
            endcase
        end else begin
            next_st.ack = 1'b0;
        end

        // Writes land at the edge where waitrequest is low.
        if (avs_write && st.ack) begin
            case (avs_address)
                bmp_pkg::OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        next_st.cfg.invert = avs_writedata[bmp_pkg::CB_INVERT];
                        next_st.cfg.run_max = avs_writedata[bmp_pkg::CB_RUN_MAX];
                        next_st.cfg.limit = avs_writedata[bmp_pkg::CB_LIMIT];
                        next_st.cfg.amp = avs_writedata[bmp_pkg::CB_AMP];
                        next_st.cfg.ultra = avs_writedata[bmp_pkg::CB_ULTRA];
                        next_st.cfg.bl_en = avs_writedata[bmp_pkg::CB_BL_EN];
                        next_st.cfg.acc_en = avs_writedata[bmp_pkg::CB_ACC_EN];
                        next_st.cfg.enc_type[0] = avs_writedata[bmp_pkg::CB_ENC_LO];
                    end
                    if (avs_byteenable[1]) begin
                        next_st.cfg.enc_type[1] = avs_writedata[bmp_pkg::CB_ENC_LO + 1];
                    end
                end
                bmp_pkg::OFS_WORK_SPEED: next_st.cfg.work_speed =
                    24'((32'(st.cfg.work_speed) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_MAX_SPEED: next_st.cfg.max_speed =
                    24'((32'(st.cfg.max_speed) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_BL_STEPS: next_st.cfg.bl_steps =
                    16'((32'(st.cfg.bl_steps) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_BL_SPEED: next_st.cfg.bl_speed =
                    24'((32'(st.cfg.bl_speed) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_ACCEL: next_st.cfg.accel =
                    24'((32'(st.cfg.accel) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_DECEL: next_st.cfg.decel =
                    24'((32'(st.cfg.decel) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_POLES: next_st.cfg.poles =
                    8'((32'(st.cfg.poles) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_ENC_CPT: next_st.cfg.enc_cpt =
                    16'((32'(st.cfg.enc_cpt) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_MAX_VOLT: next_st.cfg.max_volt =
                    16'((32'(st.cfg.max_volt) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_NOM_CURR: next_st.cfg.nom_curr =
                    16'((32'(st.cfg.nom_curr) & ~wmask) | (avs_writedata & wmask));
                bmp_pkg::OFS_TARGET: next_st.cfg.target =
                    (st.cfg.target & ~wmask) | (avs_writedata & wmask);
                default: begin
                    // Read-only and unmapped offsets ignore writes.
                end
            endcase
        end

        // Encoder feedback: signed count, sense follows the invert setting.
        next_st.qa = enc_a;
        next_st.qb = enc_b;
        if (enc_a_p == enc_a_n && enc_b_p == enc_b_n) begin
            next_st.diff_bad = 1'b1;
        end
        if (st.run.invert) begin
            next_st.enc_pos = st.enc_pos - enc_delta;
        end else begin
            next_st.enc_pos = st.enc_pos + enc_delta;
        end
        // Electrical angle: pole pairs per turn over counts per turn.
        if (enc_delta != 32'sd0) begin
            next_st.ang_frac = st.ang_frac + 24'(st.run.poles) * 24'(bmp_pkg::ANGLE_PER_PAIR)
                / 24'd2;
        end
        if (st.run.enc_cpt != 16'h0000 && next_st.ang_frac >= 24'(st.run.enc_cpt)) begin
            next_st.ang_frac = next_st.ang_frac - 24'(st.run.enc_cpt);
            next_st.angle = (enc_delta < 32'sd0) ? st.angle - 8'h01 : st.angle + 8'h01;
        end

        // Motion sequencer.
        case (st.mode)
            bmp_pkg::BMP_IDLE: begin
                next_st.cur_mps = 32'h00000000;
                next_st.duty = 8'h00;
                next_st.step_acc = 36'h000000000;
                if (avs_write && st.ack && avs_address == bmp_pkg::OFS_CMD &&
                    avs_writedata[bmp_pkg::CMD_GO] && avs_byteenable[0]) begin
                    next_st.run = st.cfg;
                    next_st.mode = bmp_pkg::BMP_MAIN;
                    next_st.goal = st.cfg.target;
                    next_st.overshoot = 1'b0;
                    // Positive count: finish moving down; negative: finish moving up.
                    if (st.cfg.bl_en && st.cfg.bl_steps != 16'sd0 &&
                        ((st.cfg.bl_steps > 16'sd0 && st.cfg.target > st.pos) ||
                         (st.cfg.bl_steps < 16'sd0 && st.cfg.target < st.pos))) begin
                        next_st.goal = st.cfg.target + 32'(st.cfg.bl_steps);
                        next_st.overshoot = 1'b1;
                    end
                end
            end
            bmp_pkg::BMP_MAIN, bmp_pkg::BMP_RETURN: begin
                next_st.dir = (st.goal > st.pos);
                // Speed profile: target speed at once without acceleration, otherwise updated once per profile period.
                if (!st.run.acc_en) begin
                    next_st.cur_mps = tgt_mps;
                end else if (ms_tick) begin
                    if (80'(v_sq) >= brake_dist || st.cur_mps > tgt_mps) begin
                        next_st.cur_mps = (st.cur_mps > floor_mps + 32'(st.run.decel)) ?
                            st.cur_mps - 32'(st.run.decel) : floor_mps;
                    end else if (st.cur_mps < tgt_mps) begin
                        next_st.cur_mps = (tgt_mps - st.cur_mps > 32'(st.run.accel)) ?
                            st.cur_mps + 32'(st.run.accel) : tgt_mps;
                    end
                    if (st.cur_mps < floor_mps) begin
                        next_st.cur_mps = floor_mps;
                    end
                end
                // Drive effort backs off while over a nominal limit, motion continues.
                if (ms_tick) begin
                    if (over_limit) begin
                        next_st.duty = (st.duty != 8'h00) ? st.duty - 8'h01 : 8'h00;
                    end else if (st.duty != 8'hff) begin
                        next_st.duty = st.duty + 8'h01;
                    end
                end
                // Step generation from the speed accumulator.
                if (st.pos == st.goal) begin
                    if (st.mode == bmp_pkg::BMP_MAIN && st.overshoot) begin
                        next_st.mode = bmp_pkg::BMP_RETURN;
                        next_st.goal = st.run.target;
                        next_st.cur_mps = floor_mps;
                    end else begin
                        next_st.mode = bmp_pkg::BMP_HOLD;
                    end
                end else if (st.step_acc + 36'(st.cur_mps) >= bmp_pkg::STEP_THRESH) begin
                    next_st.step_acc = st.step_acc + 36'(st.cur_mps) - bmp_pkg::STEP_THRESH;
                    next_st.step = 1'b1;
                    next_st.pos = st.dir ? st.pos + 32'sd1 : st.pos - 32'sd1;
                end else begin
                    next_st.step_acc = st.step_acc + 36'(st.cur_mps);
                end
                if (avs_write && st.ack && avs_address == bmp_pkg::OFS_CMD &&
                    avs_writedata[bmp_pkg::CMD_STOP] && avs_byteenable[0]) begin
                    next_st.mode = bmp_pkg::BMP_HOLD;
                end
            end
            bmp_pkg::BMP_HOLD: begin
                // First finished move marks the rotor position as known.
                next_st.aligned = 1'b1;
                next_st.mode = bmp_pkg::BMP_IDLE;
            end
            default: begin
                next_st.mode = bmp_pkg::BMP_IDLE;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            next_st_reset();
        end else begin
            st <= next_st;
        end
    end

    // Reset values of every state field.
    task automatic next_st_reset();
        st <= '0;
        st.mode <= bmp_pkg::BMP_IDLE;
        st.cfg.work_speed <= bmp_pkg::RST_WORK_SPEED;
        st.cfg.max_speed <= bmp_pkg::RST_MAX_SPEED;
        st.cfg.bl_speed <= bmp_pkg::RST_BL_SPEED;
        st.cfg.accel <= bmp_pkg::RST_ACCEL;
        st.cfg.decel <= bmp_pkg::RST_DECEL;
        st.cfg.poles <= bmp_pkg::RST_POLES;
        st.cfg.enc_cpt <= bmp_pkg::RST_ENC_CPT;
        st.cfg.max_volt <= bmp_pkg::RST_MAX_VOLT;
        st.cfg.nom_curr <= bmp_pkg::RST_NOM_CURR;
        st.run.poles <= bmp_pkg::RST_POLES;
        st.run.enc_cpt <= bmp_pkg::RST_ENC_CPT;
        st.run.max_volt <= bmp_pkg::RST_MAX_VOLT;
        st.run.nom_curr <= bmp_pkg::RST_NOM_CURR;
    endtask

endmodule

/* tb/bmp_motor_model.sv */
/* Motor and quadrature encoder model at the far side of the motion block.
   Assumes the step output is a one-cycle pulse on the shared clock. */
`timescale 1ns/1ps
module bmp_motor_model (
    input wire logic clock,
    input wire bmp_pkg::bmp_drive_s drive,
    input wire logic over,
    output logic enc_a_p,
    output logic enc_a_n,
    output logic enc_b_p,
    output logic enc_b_n,
    output bmp_pkg::bmp_meas_s meas
);
    logic [1:0] phase = 2'h0; // Quadrature state index.
    // Each step turns the shaft one encoder edge in the commanded direction.
    always @(posedge clock) begin
        if (drive.step) begin
            phase <= drive.dir ? phase + 2'h1 : phase - 2'h1;
        end
    end
    // Channel a leads channel b when turning upwards.
    assign enc_a_p = phase[1] ^ phase[0];
    assign enc_a_n = !enc_a_p;
    assign enc_b_p = phase[1];
    assign enc_b_n = !enc_b_p;
    // Over-limit makes the terminal voltage reading exceed any setting below 16'hffff.
    assign meas = '{speed: 24'h0, current: 16'h0064, voltage: over ? 16'hffff : 16'h03e8};
endmodule

/* tb/bmp_motion_ctrl_props.sv */
/* Port checker for the motion block, bound to its top module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module bmp_motion_ctrl_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire bmp_pkg::bmp_meas_s meas,
    input wire bmp_pkg::bmp_drive_s drive,
    input wire logic busy,
    input wire logic rotor_aligned
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic cmd_wr; // A write to the command register completes.
    assign cmd_wr = avs_write && !avs_waitrequest && avs_address == bmp_pkg::OFS_CMD;
    AST_WAIT_ONE: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait cycle");
    AST_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    AST_STEP_PULSE: assert property (drive.step |=> !drive.step)
        else $error("step pulse longer than one cycle");
    AST_STEP_BUSY: assert property (drive.step |-> busy)
        else $error("step while idle");
    AST_GO_BUSY: assert property (cmd_wr && avs_writedata[0] && !busy |-> ##[1:2] busy)
        else $error("go did not start a move");
    AST_STOP_IDLE: assert property (cmd_wr && avs_writedata[1] && busy |-> ##[1:4] !busy)
        else $error("stop did not end the move");
    AST_ALIGN_KEEP: assert property ($past(rotor_aligned) && !$past(rst) |-> rotor_aligned)
        else $error("aligned flag dropped");
    AST_VOLT_DUTY: assert property (busy && $past(busy) && meas.voltage == 16'hffff &&
        $past(meas.voltage) == 16'hffff |-> drive.duty <= $past(drive.duty))
        else $error("duty rose while over voltage");
    cover property (drive.step);
    cover property ($rose(rotor_aligned));
    cover property (cmd_wr && busy);
endmodule
bind bmp_motion_ctrl bmp_motion_ctrl_props u_props (.*);

/* tb/testbench.sv */
/* Self-checking bench for the motion block driving the motor model.
   Assumes a 25 MHz clock and registers reached over Avalon-MM. */
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, enc_a_p, enc_a_n, enc_b_p, enc_b_n, busy, rotor_aligned;
    logic over = 1'b0; // Forces the model over its voltage limit.
    logic sdir = 1'b0; // Direction seen at the last step.
    bmp_pkg::bmp_meas_s meas;
    bmp_pkg::bmp_drive_s drive;
    int err_total = 0;
    int checked = 0;
    initial forever #20 clock = !clock;
    bmp_motion_ctrl DUT (.*);
    bmp_motor_model u_motor (.*);
    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One Avalon-MM access held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    // Starts a move, optionally stops it, and waits for the end.
    task automatic run(input logic [31:0] ctl, input logic [31:0] tgt, input int stop_at);
        bus(1'b1, bmp_pkg::OFS_CTRL, ctl);
        bus(1'b1, bmp_pkg::OFS_TARGET, tgt);
        bus(1'b1, bmp_pkg::OFS_CMD, 32'h1);
        if (stop_at > 0) begin
            repeat (stop_at) @(posedge clock);
            bus(1'b1, bmp_pkg::OFS_CMD, 32'h2);
        end
        for (int n = 0; n < 40000 && busy !== 1'b0; n++) begin
            @(posedge clock);
            if (drive.step === 1'b1) sdir = drive.dir;
        end
        chk("move ended", 32'(busy), 32'h0);
        bus(1'b0, bmp_pkg::OFS_POSITION, 32'h0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (95000) @(posedge clock);
        err_total++;
        test_done();
    end
    // Reset values and thermal current scaled to peak.
    task automatic scn_reset();
        bus(1'b0, bmp_pkg::OFS_WORK_SPEED, 32'h0);
        chk("work speed reset", q, {8'h00, bmp_pkg::RST_WORK_SPEED});
        bus(1'b0, 8'h80, 32'h0);
        chk("unmapped read", q, 32'h0);
        chk("peak current", 32'(drive.current_ref), 32'h2c3);
    endtask
    // Move up at maximum speed while over voltage.
    task automatic scn_up();
        bus(1'b1, bmp_pkg::OFS_MAX_SPEED, 32'h00004e20);
        over <= 1'b1;
        run(32'h2, 32'h5, 0);
        over <= 1'b0;
        chk("position up", q, 32'h5);
        chk("dir up", 32'(sdir), 32'h1);
        chk("aligned", 32'(rotor_aligned), 32'h1);
        chk("angle", 32'(drive.angle), 32'h1);
        bus(1'b0, bmp_pkg::OFS_ENC_POS, 32'h0);
        chk("encoder up", q, 32'h5);
    endtask
    // Move down with the direction inverted.
    task automatic scn_inv();
        run(32'h3, 32'h2, 0);
        chk("position down", q, 32'h2);
        chk("dir inverted", 32'(sdir), 32'h1);
        bus(1'b0, bmp_pkg::OFS_ENC_POS, 32'h0);
        chk("encoder inverted", q, 32'h2);
    endtask
    // A long move cut short by stop.
    task automatic scn_stop();
        run(32'h2, 32'h000003e8, 3000);
        chk("stopped short", 32'(q > 32'h2 && q < 32'h3e8), 32'h1);
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        scn_reset();
        scn_up();
        scn_inv();
        scn_stop();
        test_done();
    end
endmodule
